/* File: rtl/rcpm_defs.svh */
/*
  Offsets, fields, reset values and timing counts of the controller.
  Assumes a 250 MHz core clock; the clock half-period is the timing unit.
*/
`ifndef RCPM_DEFS_SVH
`define RCPM_DEFS_SVH

// Clock and timing
`define CLK_NS 4
`define DRV_TCL 1024
`define DRV_CYC ((`DRV_TCL * `CLK_NS / 2) / `CLK_NS)
`define LONG_TCL 1044
`define LONG_EXTRA_NS 500
`define LONG_CYC ((`LONG_TCL * `CLK_NS / 2) / `CLK_NS + (`LONG_EXTRA_NS + `CLK_NS - 1) / `CLK_NS)
`define WAKE_NS 40
`define WAKE_CYC ((`WAKE_NS + `CLK_NS - 1) / `CLK_NS)
`define CNT_W 12
`define WAKE_W 4

// Register byte offsets
`define ADDR_CTRL 12'h000
`define ADDR_FEI 12'h004
`define ADDR_STAT 12'h008
`define ADDR_CFG 12'h00c

// Control register fields
`define CTRL_IDLE 0
`define CTRL_POWER_DOWN_INSTR 1
`define CTRL_VREG 2
`define CTRL_LPDIS 3
`define CTRL_BIDIR 4
`define CTRL_PDSEL 5
`define CTRL_SWRST 6
`define CTRL_RDYPOL 7
`define CTRL_RDYEN 8

// Status register fields
`define STAT_CPU 0
`define STAT_CLK 1
`define STAT_LPREF 2
`define STAT_REFUSED 3
`define STAT_FLAGS_LO 8
`define STAT_FLAGS_HI 12

// Sampling masks per reset kind
`define MASK_FULL 16'hffff
`define MASK_SHORT 16'h1fff
`define MASK_SOFT 16'h1fc0

// Reset flags: power-on, async hw, long hw, short hw, software, watchdog
`define FLAG_POR 5'h1e
`define FLAG_AHW 5'h0e
`define FLAG_LHW 5'h0e
`define FLAG_SHW 5'h06
`define FLAG_SW 5'h02
`define FLAG_WDT 5'h03

// Reset values
`define CFG_RST 16'h0000
`define FEI_RST 16'h0000
`define FLAGS_RST 5'h00

`endif

/* File: rtl/rcpm_pkg.sv */
/*
  Types of the reset configuration and power mode controller.
  Assumes nothing beyond the constants header.
*/
package rcpm_pkg;

  typedef enum {
    ST_RUN, ST_HWRST, ST_INTRST, ST_ENTRY, ST_IDLE, ST_PDPROT, ST_PDINT, ST_WAKE
  } state_type;

  typedef enum {RK_POR, RK_AHW, RK_SHW, RK_LHW, RK_SW, RK_WDT} rkind_type;

  typedef struct packed {
    logic rdy_en;
    logic rdy_pol;
    logic pd_sel;
    logic bidir_en;
    logic lp_dis;
    logic vreg_off;
  } ctrl_type;

  typedef struct packed {
    logic [7:0] level;
    logic [7:0] enable;
  } fei_type;

  typedef struct packed {
    logic wr;
    logic [11:0] addr;
  } aphase_type;

endpackage

/* File: rtl/cycle_counter.sv */
/*
  Saturating cycle counter used to time reset phases.
  Assumes clear and enable come from the controller's own state.
*/
`include "rcpm_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module cycle_counter (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Control
  input wire logic clear,
  input wire logic enable,
  // Count
  output logic [`CNT_W-1:0] count
);

  logic [`CNT_W-1:0] count_reg;
  logic [`CNT_W-1:0] count_next;

  // Saturate so a stuck pin cannot wrap into a short reading
  always_comb begin
    count_next = count_reg;
    if (clear) begin
      count_next = '0;
    end else if (enable && (count_reg != '1)) begin
      count_next = count_reg + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign count = count_reg;

endmodule

`default_nettype wire

/* File: rtl/wake_filter.sv */
/*
  Per-pin minimum-width filter for the fast external interrupt pins.
  Assumes pins are synchronous to the clock; arm is high only in power-down.
*/
`include "rcpm_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module wake_filter (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Pins and their configuration
  input wire logic [7:0] pins,
  input wire logic [7:0] enable,
  input wire logic [7:0] level,
  input wire logic arm,
  // Results
  output logic wake,
  output logic all_inactive
);

  logic [7:0] hit;
  logic [7:0] active;

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      logic [`WAKE_W-1:0] cnt_reg;
      logic [`WAKE_W-1:0] cnt_next;
      assign active[i] = enable[i] && (pins[i] == level[i]);
      // Count consecutive active cycles, hold at the threshold
      always_comb begin
        cnt_next = '0;
        if (arm && active[i]) begin
          cnt_next = (cnt_reg == `WAKE_W'(`WAKE_CYC)) ? cnt_reg : cnt_reg + 1'b1;
        end
      end
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          cnt_reg <= '0;
        end else begin
          cnt_reg <= cnt_next;
        end
      end
      assign hit[i] = (cnt_reg == `WAKE_W'(`WAKE_CYC));
    end
  endgenerate

  // Shorter pulses are treated as noise and do not wake
  assign wake = |hit;
  assign all_inactive = ~|active;

endmodule

`default_nettype wire

/* File: rtl/reset_config_power_mode_ctrl.sv */
/*
  Reset configuration latch and idle / power-down controller with an
  AHB-Lite register slave.
  Assumes a single AHB-Lite master, synchronous pin inputs and that the
  CPU reports pending bus work and the ready level of its last access.
*/
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
// Notes on behaviour
// - Latch config port at every reset end
// - Power-on, async, long reset take all bits
// - Short: high 4..0 and low; soft: fewer
// - Software reset drives pin for 1024 half-periods
// - Bidir with RC low: retype as short
// - Wait for bus work before low power
// - Refuse entry when ready never came
// - Idle stops CPU, peripherals keep running
// - Any interrupt ends idle
// - Power-down stops clock and watchdog
// - Low-power oscillator lets main oscillator stop
// - Adopt low-power oscillator until software disables
// - Main oscillator keeps running in power-down unless low-power one adopted
// - Select bit chooses protected or interruptible
// - Protected needs NMI low, exits by reset
// - Interruptible needs enabled pins inactive
// - Interruptible wakes on reset or interrupts
// - Brief pin pulses with RC high: synchronous
`include "rcpm_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module reset_config_power_mode_ctrl (
  // AHB-Lite clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Configuration and reset pins
  input wire logic [15:0] config_port,
  input wire logic reset_input_pin,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic powerdown_rc_pin,
  input wire logic external_access_select,
  // Wake-up and oscillator pins
  input wire logic nmi_pin,
  input wire logic [7:0] fast_ext_int_pin,
  input wire logic low_power_osc_running,
  // Core status
  input wire logic bus_pending,
  input wire logic ready_last_level,
  input wire logic irq_request,
  input wire logic rtc_irq,
  input wire logic can_i2c_irq,
  input wire logic watchdog_expire,
  // Mode outputs
  output logic cpu_stop,
  output logic periph_stop,
  output logic clk_stop,
  output logic main_osc_stop,
  output logic wdt_hold,
  output logic rtc_ref_lp,
  output logic regulator_off,
  output logic wake_irq_valid,
  output logic sys_reset
);

  rcpm_pkg::state_type state_reg, state_next;
  rcpm_pkg::rkind_type kind_reg, kind_next;
  rcpm_pkg::ctrl_type ctrl_reg, ctrl_next;
  rcpm_pkg::fei_type fei_reg, fei_next;
  rcpm_pkg::aphase_type aph_reg, aph_next;
  logic [15:0] cfg_reg, cfg_next;
  logic [4:0] flags_reg, flags_next;
  logic [31:0] hrdata_next;
  logic idle_cmd_reg, idle_cmd_next;
  logic pd_cmd_reg, pd_cmd_next;
  logic sw_cmd_reg, sw_cmd_next;
  logic refused_reg, refused_next;
  logic refuse_evt;
  logic want_pd_reg, want_pd_next;
  logic drive_reg, drive_next;
  logic por_pend_reg;
  logic lp_ref_reg, lp_ref_next;
  logic cpu_stop_reg, pd_reg, wake_irq_reg, sys_reset_reg, oe_reg, hready_reg;
  logic finish;
  logic pin_low;
  logic wr_ctrl, wr_fei, wr_stat;
  logic [`CNT_W-1:0] count;
  logic wake_pin, fei_quiet;
  logic [15:0] mask;
  logic [4:0] kind_flags;

  // Own drive shows on the pin; not a hw reset
  assign pin_low = !reset_input_pin && !oe_reg;

  cycle_counter u_counter (
    .clk(hclk),
    .rstn(hresetn),
    .clear(state_next != state_reg),
    .enable((state_reg == rcpm_pkg::ST_HWRST) || (state_reg == rcpm_pkg::ST_INTRST)),
    .count(count)
  );

  wake_filter u_wake (
    .clk(hclk),
    .rstn(hresetn),
    .pins(fast_ext_int_pin),
    .enable(fei_reg.enable),
    .level(fei_reg.level),
    .arm(state_reg == rcpm_pkg::ST_PDINT),
    .wake(wake_pin),
    .all_inactive(fei_quiet)
  );

  // Bus address phase capture; the slave never waits, so reads are zero-wait
  always_comb begin
    aph_next.wr = hsel && htrans[1] && hready && hwrite;
    aph_next.addr = haddr[11:0];
    hrdata_next = 32'h0000_0000;
    if (hsel && htrans[1] && hready && !hwrite) begin
      case (haddr[11:0])
        `ADDR_CTRL: begin
          hrdata_next[`CTRL_VREG] = ctrl_reg.vreg_off;
          hrdata_next[`CTRL_LPDIS] = ctrl_reg.lp_dis;
          hrdata_next[`CTRL_BIDIR] = ctrl_reg.bidir_en;
          hrdata_next[`CTRL_PDSEL] = ctrl_reg.pd_sel;
          hrdata_next[`CTRL_RDYPOL] = ctrl_reg.rdy_pol;
          hrdata_next[`CTRL_RDYEN] = ctrl_reg.rdy_en;
        end
        `ADDR_FEI: hrdata_next[15:0] = fei_reg;
        `ADDR_STAT: begin
          hrdata_next[`STAT_CPU] = cpu_stop_reg;
          hrdata_next[`STAT_CLK] = pd_reg;
          hrdata_next[`STAT_LPREF] = lp_ref_reg;
          hrdata_next[`STAT_REFUSED] = refused_reg;
          hrdata_next[`STAT_FLAGS_HI:`STAT_FLAGS_LO] = flags_reg;
        end
        `ADDR_CFG: hrdata_next[15:0] = cfg_reg;
        default: hrdata_next = 32'h0000_0000;
      endcase
    end
  end

  assign wr_ctrl = aph_reg.wr && (aph_reg.addr == `ADDR_CTRL);
  assign wr_fei = aph_reg.wr && (aph_reg.addr == `ADDR_FEI);
  assign wr_stat = aph_reg.wr && (aph_reg.addr == `ADDR_STAT);

  // Register writes; commands are one-cycle pulses
  always_comb begin
    ctrl_next = ctrl_reg;
    fei_next = fei_reg;
    idle_cmd_next = 1'b0;
    pd_cmd_next = 1'b0;
    sw_cmd_next = 1'b0;
    if (wr_ctrl) begin
      ctrl_next.vreg_off = hwdata[`CTRL_VREG];
      ctrl_next.lp_dis = hwdata[`CTRL_LPDIS];
      ctrl_next.bidir_en = hwdata[`CTRL_BIDIR];
      ctrl_next.pd_sel = hwdata[`CTRL_PDSEL];
      ctrl_next.rdy_pol = hwdata[`CTRL_RDYPOL];
      ctrl_next.rdy_en = hwdata[`CTRL_RDYEN];
      idle_cmd_next = hwdata[`CTRL_IDLE];
      pd_cmd_next = hwdata[`CTRL_POWER_DOWN_INSTR];
      sw_cmd_next = hwdata[`CTRL_SWRST];
    end
    if (wr_fei) begin
      fei_next = hwdata[15:0];
    end
    // Set wins over a write-one clear in the same cycle
    refused_next = refused_reg;
    if (wr_stat && hwdata[`STAT_REFUSED]) begin
      refused_next = 1'b0;
    end
    if (refuse_evt) begin
      refused_next = 1'b1;
    end
  end

  // Oscillator reference: sticky once seen, dropped only by software
  always_comb begin
    lp_ref_next = lp_ref_reg || low_power_osc_running;
    if (ctrl_reg.lp_dis) begin
      lp_ref_next = 1'b0;
    end
  end

  // Mode and reset sequencer
  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    want_pd_next = want_pd_reg;
    drive_next = drive_reg;
    refuse_evt = 1'b0;
    finish = 1'b0;
    case (state_reg)
      rcpm_pkg::ST_RUN: begin
        if (sw_cmd_reg) begin
          state_next = rcpm_pkg::ST_INTRST;
          kind_next = rcpm_pkg::RK_SW;
        end else if (idle_cmd_reg || pd_cmd_reg) begin
          state_next = rcpm_pkg::ST_ENTRY;
          want_pd_next = pd_cmd_reg;
        end
      end
      rcpm_pkg::ST_ENTRY: begin
        if (!bus_pending) begin
          if (ctrl_reg.rdy_en && (ready_last_level != ctrl_reg.rdy_pol)) begin
            refuse_evt = 1'b1;
            state_next = rcpm_pkg::ST_RUN;
          end else if (!want_pd_reg) begin
            state_next = rcpm_pkg::ST_IDLE;
          end else if (!ctrl_reg.pd_sel) begin
            if (!nmi_pin) begin
              state_next = rcpm_pkg::ST_PDPROT;
            end else begin
              refuse_evt = 1'b1;
              state_next = rcpm_pkg::ST_RUN;
            end
          end else if (fei_quiet) begin
            state_next = rcpm_pkg::ST_PDINT;
          end else begin
            refuse_evt = 1'b1;
            state_next = rcpm_pkg::ST_RUN;
          end
        end
      end
      rcpm_pkg::ST_IDLE: begin
        if (irq_request || rtc_irq || can_i2c_irq) begin
          state_next = rcpm_pkg::ST_RUN;
        end
      end
      rcpm_pkg::ST_PDPROT: begin
        state_next = rcpm_pkg::ST_PDPROT; // Only the reset pin leaves
      end
      rcpm_pkg::ST_PDINT: begin
        if (wake_pin || rtc_irq || can_i2c_irq) begin
          state_next = rcpm_pkg::ST_WAKE;
        end
      end
      rcpm_pkg::ST_WAKE: begin
        state_next = rcpm_pkg::ST_RUN;
      end
      rcpm_pkg::ST_HWRST: begin
        // Length is judged at release; the holder must allow clock settling
        if (reset_input_pin) begin
          finish = 1'b1;
          state_next = rcpm_pkg::ST_RUN;
          if (kind_reg != rcpm_pkg::RK_AHW) begin
            kind_next = (count >= `CNT_W'(`LONG_CYC)) ? rcpm_pkg::RK_LHW : rcpm_pkg::RK_SHW;
          end
        end
      end
      rcpm_pkg::ST_INTRST: begin
        if (ctrl_reg.bidir_en && !powerdown_rc_pin && !reset_input_pin) begin
          kind_next = rcpm_pkg::RK_SHW;
        end
        if (count == `CNT_W'(`DRV_CYC - 1)) begin
          finish = 1'b1;
          state_next = rcpm_pkg::ST_RUN;
        end
      end
      default: state_next = rcpm_pkg::ST_RUN;
    endcase
    // External reset overrides other states except an internal reset with bidir and RC low; watchdog acts only in run
    if (pin_low && (state_reg != rcpm_pkg::ST_HWRST) &&
        !((state_reg == rcpm_pkg::ST_INTRST) && ctrl_reg.bidir_en && !powerdown_rc_pin)) begin
      state_next = rcpm_pkg::ST_HWRST;
      kind_next = powerdown_rc_pin ? rcpm_pkg::RK_SHW : rcpm_pkg::RK_AHW;
      finish = 1'b0;
    end else if (watchdog_expire && (state_reg == rcpm_pkg::ST_RUN)) begin
      state_next = rcpm_pkg::ST_INTRST;
      kind_next = rcpm_pkg::RK_WDT;
    end
    if ((state_next == rcpm_pkg::ST_INTRST) && (state_reg != rcpm_pkg::ST_INTRST)) begin
      drive_next = ctrl_reg.bidir_en && powerdown_rc_pin && external_access_select;
    end else if (state_next != rcpm_pkg::ST_INTRST) begin
      drive_next = 1'b0;
    end
  end

  // Sampling pattern and flags of the kind being finished
  always_comb begin
    case (por_pend_reg ? rcpm_pkg::RK_POR : kind_next)
      rcpm_pkg::RK_POR: begin
        mask = `MASK_FULL;
        kind_flags = `FLAG_POR;
      end
      rcpm_pkg::RK_AHW: begin
        mask = `MASK_FULL;
        kind_flags = `FLAG_AHW;
      end
      rcpm_pkg::RK_LHW: begin
        mask = `MASK_FULL;
        kind_flags = `FLAG_LHW;
      end
      rcpm_pkg::RK_SHW: begin
        mask = `MASK_SHORT;
        kind_flags = `FLAG_SHW;
      end
      rcpm_pkg::RK_WDT: begin
        mask = `MASK_SOFT;
        kind_flags = `FLAG_WDT;
      end
      default: begin
        mask = `MASK_SOFT;
        kind_flags = `FLAG_SW;
      end
    endcase
    cfg_next = cfg_reg;
    flags_next = flags_reg;
    if (finish || por_pend_reg) begin
      cfg_next = (cfg_reg & ~mask) | (config_port & mask);
      flags_next = kind_flags;
    end
  end

  // State registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= rcpm_pkg::ST_RUN;
      kind_reg <= rcpm_pkg::RK_POR;
      ctrl_reg <= '0;
      fei_reg <= `FEI_RST;
      aph_reg <= '0;
      cfg_reg <= `CFG_RST;
      flags_reg <= `FLAGS_RST;
      idle_cmd_reg <= 1'b0;
      pd_cmd_reg <= 1'b0;
      sw_cmd_reg <= 1'b0;
      refused_reg <= 1'b0;
      want_pd_reg <= 1'b0;
      drive_reg <= 1'b0;
      por_pend_reg <= 1'b1;
      lp_ref_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      ctrl_reg <= ctrl_next;
      fei_reg <= fei_next;
      aph_reg <= aph_next;
      cfg_reg <= cfg_next;
      flags_reg <= flags_next;
      idle_cmd_reg <= idle_cmd_next;
      pd_cmd_reg <= pd_cmd_next;
      sw_cmd_reg <= sw_cmd_next;
      refused_reg <= refused_next;
      want_pd_reg <= want_pd_next;
      drive_reg <= drive_next;
      por_pend_reg <= 1'b0; // Port captured on the first edge after release
      lp_ref_reg <= lp_ref_next;
    end
  end

  // Output registers, aligned with the state they belong to
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hready_reg <= 1'b0;
      cpu_stop_reg <= 1'b0;
      pd_reg <= 1'b0;
      wake_irq_reg <= 1'b0;
      sys_reset_reg <= 1'b1;
      oe_reg <= 1'b0;
      main_osc_stop <= 1'b0;
      rtc_ref_lp <= 1'b0;
      regulator_off <= 1'b0;
    end else begin
      hrdata <= hrdata_next;
      hready_reg <= 1'b1;
      cpu_stop_reg <= (state_next == rcpm_pkg::ST_IDLE) || (state_next == rcpm_pkg::ST_PDPROT) ||
                      (state_next == rcpm_pkg::ST_PDINT);
      pd_reg <= (state_next == rcpm_pkg::ST_PDPROT) || (state_next == rcpm_pkg::ST_PDINT);
      wake_irq_reg <= (state_reg == rcpm_pkg::ST_WAKE); // Clock back first, then irq
      sys_reset_reg <= (state_next == rcpm_pkg::ST_HWRST) || (state_next == rcpm_pkg::ST_INTRST);
      oe_reg <= drive_next;
      main_osc_stop <= ((state_next == rcpm_pkg::ST_PDPROT) || (state_next == rcpm_pkg::ST_PDINT)) &&
                       lp_ref_next;
      rtc_ref_lp <= lp_ref_next;
      regulator_off <= ctrl_next.vreg_off;
    end
  end

  // Peripherals, clock and watchdog all hold together in power-down
  assign cpu_stop = cpu_stop_reg;
  assign periph_stop = pd_reg;
  assign clk_stop = pd_reg;
  assign wdt_hold = pd_reg;
  assign wake_irq_valid = wake_irq_reg;
  assign sys_reset = sys_reset_reg;
  assign reset_pin_oe = oe_reg;
  assign reset_pin_out = 1'b0; // Open-drain: only ever pulls low
  assign hreadyout = hready_reg;
  assign hresp = 1'b0;

endmodule

`default_nettype wire

/* File: verif/rcpm_properties.sv */
/*
  Checker of mode, wake and reset-drive relations of the controller.
  Assumes it is bound to the controller and sees its ports only.
*/
`include "rcpm_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module rcpm_properties (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Pins
  input wire logic reset_input_pin,
  input wire logic reset_pin_oe,
  input wire logic powerdown_rc_pin,
  input wire logic external_access_select,
  input wire logic [7:0] fast_ext_int_pin,
  // Core events
  input wire logic irq_request,
  input wire logic rtc_irq,
  input wire logic can_i2c_irq,
  // Mode outputs
  input wire logic cpu_stop,
  input wire logic periph_stop,
  input wire logic clk_stop,
  input wire logic main_osc_stop,
  input wire logic wdt_hold,
  input wire logic rtc_ref_lp,
  input wire logic wake_irq_valid,
  input wire logic sys_reset
);
  logic [`CNT_W-1:0] oe_cnt_reg;
  logic [`CNT_W-1:0] oe_cnt_next;
  logic cause;

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Length of the current own drive of the reset pin
  always_comb oe_cnt_next = reset_pin_oe ? oe_cnt_reg + 1'h1 : '0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) oe_cnt_reg <= '0;
    else oe_cnt_reg <= oe_cnt_next;
  end

  // Events able to end power-down; the bench drives enabled pins active high
  assign cause = !reset_input_pin || rtc_irq || can_i2c_irq || (|fast_ext_int_pin);

  // Clock restarts first, the waking request follows
  sequence wake_s;
    !clk_stop ##[1:2] wake_irq_valid;
  endsequence

  drive_len_a: assert property ($fell(reset_pin_oe) |-> oe_cnt_reg == `DRV_CYC)
    else $error("reset pin drive length wrong");
  drive_cond_a: assert property (reset_pin_oe |-> powerdown_rc_pin && external_access_select && sys_reset)
    else $error("reset pin driven without cause");
  pd_hold_a: assert property (clk_stop |-> cpu_stop && periph_stop && wdt_hold)
    else $error("power-down leaves a part running");
  osc_choice_a: assert property (main_osc_stop == (clk_stop && rtc_ref_lp))
    else $error("main oscillator state wrong");
  idle_exit_a: assert property (cpu_stop && !clk_stop && (irq_request || rtc_irq || can_i2c_irq) |=> !cpu_stop)
    else $error("idle not ended by interrupt");
  wake_cause_a: assert property ($fell(clk_stop) |-> $past(cause) || $past(cause, 2))
    else $error("power-down left without event");
  wake_pulse_a: assert property ($fell(clk_stop) && $past(reset_input_pin) |-> wake_s)
    else $error("waking request not presented");
  pulse_one_a: assert property (wake_irq_valid |=> !wake_irq_valid)
    else $error("waking request longer than one cycle");
  pin_reset_a: assert property (!reset_input_pin && !reset_pin_oe |-> ##[1:2] sys_reset)
    else $error("reset pin low without reset");
endmodule

bind reset_config_power_mode_ctrl rcpm_properties chk_u (.*);

`default_nettype wire

/* File: verif/rcpm_partner.sv */
/*
  Model of the external reset circuit and the fast interrupt sources.
  Assumes a pull-up on the reset line, pulled low by either party.
*/
`timescale 1ns/1ns
`default_nettype none

module rcpm_partner (
  // Clock
  input wire logic hclk,
  // Reset line
  input wire logic reset_pin_oe,
  output logic reset_input_pin,
  // Interrupt sources
  output logic [7:0] fast_ext_int_pin
);
  logic ext_low = 1'h0;
  logic [7:0] lvl = 8'h00;

  // Wired line: low while either side pulls, else the pull-up wins
  assign reset_input_pin = !(ext_low || reset_pin_oe);
  assign fast_ext_int_pin = lvl;

  // Hold the line low long enough for clocks to settle
  task reset_pulse(input int n);
    @(posedge hclk) ext_low <= 1'h1;
    repeat (n) @(posedge hclk);
    ext_low <= 1'h0;
  endtask

  task set_int(input logic [7:0] v);
    @(posedge hclk) lvl <= v;
  endtask

  // Width under the minimum is a deliberate stress case
  task int_pulse(input int i, input int n);
    @(posedge hclk) lvl[i] <= 1'h1;
    repeat (n) @(posedge hclk);
    lvl[i] <= 1'h0;
  endtask
endmodule

`default_nettype wire

/* File: verif/tb_top.sv */
/*
  Bench of the reset configuration and power mode controller.
  Assumes the partner model on the pins.
*/
`include "rcpm_defs.svh"
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, d;
  logic [1:0] htrans = 2'h0;
  logic [15:0] config_port = 16'h3c5a, cfg_exp, p;
  logic powerdown_rc_pin = 1'h1, external_access_select = 1'h0, nmi_pin = 1'h1, low_power_osc_running = 1'h0;
  logic bus_pending = 1'h0, ready_last_level = 1'h0, irq_request = 1'h0, rtc_irq = 1'h0, watchdog_expire = 1'h0;
  logic reset_input_pin, reset_pin_out, reset_pin_oe, cpu_stop, periph_stop, clk_stop, main_osc_stop;
  logic wdt_hold, rtc_ref_lp, regulator_off, wake_irq_valid, sys_reset, saw_oe, can_i2c_irq = 1'h0;
  logic [7:0] fast_ext_int_pin;
  int bad_count = 0, num_checks = 0;
  // Mode rows: ctrl, {nmi, pin0, ready level}, {cpu_stop, clk_stop, refused}
  logic [14:0] rows [7] = '{{9'h001, 3'h4, 3'h4}, {9'h006, 3'h0, 3'h6}, {9'h006, 3'h4, 3'h1},
    {9'h026, 3'h4, 3'h6}, {9'h026, 3'h6, 3'h1}, {9'h181, 3'h4, 3'h1}, {9'h181, 3'h5, 3'h4}};
  // Reset kinds: rc pin, access select, sampling mask, flags
  logic [22:0] rk [6] = '{{1'h1, 1'h0, `MASK_SHORT, `FLAG_SHW}, {1'h1, 1'h0, `MASK_FULL, `FLAG_LHW},
    {1'h0, 1'h0, `MASK_FULL, `FLAG_AHW}, {1'h1, 1'h1, `MASK_SOFT, `FLAG_SW},
    {1'h1, 1'h0, `MASK_SOFT, `FLAG_WDT}, {1'h0, 1'h1, `MASK_SHORT, `FLAG_SHW}};

  rcpm_partner partner_u (.*);
  reset_config_power_mode_ctrl dut_u (.*, .hsize(3'h2), .hready(hreadyout));

  // Clock; latch of own reset pin drive
  always #2 hclk = ~hclk;
  always @(posedge hclk) if (reset_pin_oe === 1'h1) saw_oe <= 1'h1;

  task chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Single word transfer; read data taken as the data phase ends
  task ahb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    rd = hrdata;
  endtask

  task wait_rst;
    int n;
    n = 0;
    while (sys_reset !== 1'h1 && n < 30) begin
      @(posedge hclk);
      n++;
    end
    while (sys_reset !== 1'h0 && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 3000) begin
      bad_count++;
      $display("[ERR] %0t reset never ended", $time);
    end
    repeat (2) @(posedge hclk);
  endtask

  // Enter a mode, check it, then send interrupts
  task run_row(input int i);
    nmi_pin <= rows[i][5];
    ready_last_level <= rows[i][3];
    partner_u.set_int({7'h0, rows[i][4]});
    ahb(1'h1, `ADDR_FEI, 32'h0101, d);
    ahb(1'h1, `ADDR_CTRL, {23'h0, rows[i][14:6]}, d); // regulator off first
    repeat (6) @(posedge hclk);
    chk(cpu_stop, rows[i][2]);
    chk(clk_stop, rows[i][1]);
    chk(main_osc_stop, rows[i][1] & low_power_osc_running);
    ahb(1'h0, `ADDR_STAT, 32'h0, d);
    chk(d[3], rows[i][0]);
    ahb(1'h1, `ADDR_STAT, 32'h8, d);
    partner_u.set_int(8'h00);
    irq_request <= 1'h1;
    {rtc_irq, can_i2c_irq} <= {!i[0], i[0]};
    repeat (3) @(posedge hclk);
    irq_request <= 1'h0;
    {rtc_irq, can_i2c_irq} <= 2'h0;
    @(posedge hclk);
    chk(cpu_stop, rows[i][14:6] == 9'h006 && rows[i][2]);
    if (cpu_stop === 1'h1) begin
      partner_u.reset_pulse(20);
      wait_rst;
    end
  endtask

  task note(input string s);
    $display("test %s done at %0t", s, $time);
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Timeout far above the test length
  initial begin
    repeat (40000) @(posedge hclk);
    bad_count++;
    $display("[ERR] %0t timeout", $time);
    end_sim;
  end

  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (2) @(posedge hclk);
    cfg_exp = config_port;
    ahb(1'h0, `ADDR_STAT, 32'h0, d);
    chk(d, 32'h1e00);
    ahb(1'h0, `ADDR_CFG, 32'h0, d);
    chk(d, {16'h0, cfg_exp});
    ahb(1'h0, 12'h010, 32'h0, d);
    chk(d, 32'h0);
    note("reset values");
    for (int i = 0; i < 7; i++) run_row(i);
    note("mode rows");
    // Entry must wait for outstanding bus work
    bus_pending <= 1'h1;
    ahb(1'h1, `ADDR_CTRL, 32'h1, d);
    repeat (10) @(posedge hclk);
    chk(cpu_stop, 1'h0);
    bus_pending <= 1'h0;
    repeat (4) @(posedge hclk);
    chk(cpu_stop, 1'h1);
    irq_request <= 1'h1;
    @(posedge hclk);
    irq_request <= 1'h0;
    repeat (2) @(posedge hclk);
    chk(cpu_stop, 1'h0);
    note("bus pending");
    low_power_osc_running <= 1'h1;
    repeat (4) @(posedge hclk);
    chk(rtc_ref_lp, 1'h1);
    run_row(3);
    ahb(1'h1, `ADDR_CTRL, 32'h8, d);
    repeat (4) @(posedge hclk);
    chk(rtc_ref_lp, 1'h0);
    note("oscillator");
    // Short pin pulse must not wake, a long one must
    ahb(1'h1, `ADDR_FEI, 32'h0808, d);
    ahb(1'h1, `ADDR_CTRL, 32'h26, d);
    repeat (6) @(posedge hclk);
    partner_u.int_pulse(3, 5);
    repeat (4) @(posedge hclk);
    chk(clk_stop, 1'h1);
    partner_u.int_pulse(3, `WAKE_CYC + 2);
    repeat (4) @(posedge hclk);
    chk(clk_stop, 1'h0);
    note("pin wake");
    for (int k = 0; k < 6; k++) begin
      p = ~config_port;
      config_port <= p;
      powerdown_rc_pin <= rk[k][22];
      external_access_select <= rk[k][21];
      saw_oe <= 1'h0;
      @(posedge hclk);
      if (k < 3) partner_u.reset_pulse(k == 1 ? `LONG_CYC + 50 : 20);
      else if (k == 4) watchdog_expire <= 1'h1;
      else ahb(1'h1, `ADDR_CTRL, 32'h50, d);
      if (k == 5) begin
        repeat (4) @(posedge hclk);
        partner_u.reset_pulse(20); // outside pull during internal reset
      end
      @(posedge hclk);
      watchdog_expire <= 1'h0;
      wait_rst;
      cfg_exp = (cfg_exp & ~rk[k][20:5]) | (p & rk[k][20:5]);
      ahb(1'h0, `ADDR_CFG, 32'h0, d);
      chk(d, {16'h0, cfg_exp});
      ahb(1'h0, `ADDR_STAT, 32'h0, d);
      chk(d[12:8], rk[k][4:0]);
      chk(saw_oe, k == 3);
      ahb(1'h1, `ADDR_CTRL, 32'h0, d);
    end
    note("reset kinds");
    end_sim;
  end
endmodule

`default_nettype wire
